// File: src/sla_addr_unit.sv
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module sla_addr_unit
  import sla_pkg::*;
(
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [APB_ADDR_WIDTH-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      reqValid,
  output logic                           reqReady,
  input  wire sla_req_type               req,
  output sla_ea_type                     result,
  input  wire logic                      coreWrEn,
  input  wire logic [3:0]                coreWrIdx,
  input  wire logic [15:0]               coreWrData,
  output logic                           stackErrReq,
  input  wire logic                      stackErrAck,
  output logic                           macFault
);

  logic [15:0]   default_working_reg_q [NUM_WREGS];
  logic [15:0]   stackLimit_q;
  logic [15:0]   trapAddr_q;
  logic [15:0]   pushHi_q;
  logic [15:0]   pushHi_d;
  sla_state_type state_q;
  sla_state_type state_d;
  sla_ea_type    result_q;
  sla_ea_type    result_d;
  logic          reqReady_q;
  logic          stackErr_q;
  logic          macFault_q;
  logic          macFault_d;
  logic [31:0]   prdata_q;
  logic          pready_q;
  logic          pslverr_q;

  logic          acc;
  logic [15:0]   sp;
  logic [15:0]   step;
  logic [15:0]   offVal;
  logic [15:0]   srcEa;
  logic [15:0]   dstEa;
  logic [15:0]   xEa;
  logic [15:0]   yEa;
  logic          xOk;
  logic          yOk;
  logic          srcUpd;
  logic          dstUpd;
  logic          xUpd;
  logic          yUpd;
  logic          spUpd;
  logic [15:0]   spNew;
  logic          stackHit;
  logic [15:0]   stackEa;
  logic          apbWrite;
  logic [31:0]   rdMux;
  logic          mapped;

  function automatic logic [15:0] modeEa(sla_mode_type m, logic [15:0] ptr,
                                         logic [15:0] off, logic [15:0] lit,
                                         logic [15:0] stp);
    case (m)
      MODE_PRE_INC:    modeEa = ptr + stp;
      MODE_PRE_DEC:    modeEa = ptr - stp;
      MODE_INDEXED:    modeEa = ptr + off;
      MODE_LIT_OFFSET: modeEa = ptr + lit;
      MODE_FILE:       modeEa = lit;
      default:         modeEa = ptr;
    endcase
  endfunction

  function automatic logic [15:0] modeNext(sla_mode_type m, logic [15:0] ptr,
                                           logic [15:0] stp);
    case (m)
      MODE_POST_INC, MODE_PRE_INC: modeNext = ptr + stp;
      MODE_POST_DEC, MODE_PRE_DEC: modeNext = ptr - stp;
      default:                     modeNext = ptr;
    endcase
  endfunction

  function automatic logic modeUpdates(sla_mode_type m);
    modeUpdates = (m == MODE_POST_INC) || (m == MODE_POST_DEC) ||
                  (m == MODE_PRE_INC) || (m == MODE_PRE_DEC);
  endfunction

  function automatic logic isMemMode(sla_mode_type m);
    isMemMode = (m != MODE_DIRECT);
  endfunction

  function automatic logic [15:0] macNext(sla_mac_type m, logic [15:0] ptr);
    case (m)
      MAC_INC2: macNext = ptr + MAC_STEP2;
      MAC_INC4: macNext = ptr + MAC_STEP4;
      MAC_INC6: macNext = ptr + MAC_STEP6;
      MAC_DEC2: macNext = ptr - MAC_STEP2;
      MAC_DEC4: macNext = ptr - MAC_STEP4;
      MAC_DEC6: macNext = ptr - MAC_STEP6;
      default:  macNext = ptr;
    endcase
  endfunction

  // Equal to the limit passes; only beyond it, or under data RAM, is a fault
  function automatic logic stackFault(logic [15:0] ea, logic [15:0] lim);
    stackFault = (ea > lim) || (ea < DATA_RAM_START);
  endfunction

  assign acc    = reqValid && reqReady_q;
  assign sp     = default_working_reg_q[SP_INDEX];
  assign step   = req.byteOp ? BYTE_STEP : WORD_STEP;
  assign offVal = default_working_reg_q[req.offsetIdx];
  assign srcEa  = modeEa(req.srcMode, default_working_reg_q[req.srcPtr], offVal, req.literal, step);
  assign dstEa  = modeEa(req.dstMode, default_working_reg_q[req.dstPtr], offVal, req.literal, step);
  assign xEa    = (req.xMac == MAC_INDEXED) ? default_working_reg_q[req.xPtr] + offVal : default_working_reg_q[req.xPtr];
  assign yEa    = (req.yMac == MAC_INDEXED) ? default_working_reg_q[req.yPtr] + offVal : default_working_reg_q[req.yPtr];
  // X pointers 8/9, Y pointers 10/11, indexed only via 9 and 11
  assign xOk    = ((req.xPtr == MAC_X_PLAIN) && (req.xMac != MAC_INDEXED)) ||
                  (req.xPtr == MAC_X_INDEXED);
  assign yOk    = ((req.yPtr == MAC_Y_PLAIN) && (req.yMac != MAC_INDEXED)) ||
                  (req.yPtr == MAC_Y_INDEXED);

  always_comb begin
    result_d   = '0;
    state_d    = state_q;
    pushHi_d   = pushHi_q;
    macFault_d = 1'b0;
    srcUpd     = 1'b0;
    dstUpd     = 1'b0;
    xUpd       = 1'b0;
    yUpd       = 1'b0;
    spUpd      = 1'b0;
    spNew      = sp;
    stackHit   = 1'b0;
    stackEa    = sp;
    if (state_q == ST_PUSH_HI) begin
      result_d.valid   = 1'b1;
      result_d.wrValid = 1'b1;
      result_d.wrAddr  = sp;
      result_d.wrData  = pushHi_q;
      spUpd            = 1'b1;
      spNew            = sp + WORD_STEP;
      stackHit         = stackFault(sp, stackLimit_q);
      state_d          = ST_IDLE;
    end else if (acc) begin
      result_d.valid = 1'b1;
      case (req.cmd)
        CMD_FILE: begin
          result_d.rdValid = 1'b1;
          result_d.rdAddr  = req.literal & NEAR_MASK;
          result_d.opndA   = default_working_reg_q[DEFAULT_DEFAULT_WORKING_REG];
        end
        CMD_MCU, CMD_MOVE: begin
          if (req.cmd == CMD_MCU) begin
            result_d.opndA = default_working_reg_q[req.offsetIdx];
          end
          if ((req.cmd == CMD_MCU) && (req.opnd2 == OPND_LIT)) begin
            result_d.opndB = req.literal & SHORT_LIT_MASK;
          end else if (((req.cmd == CMD_MCU) && (req.opnd2 == OPND_MEM)) ||
                       ((req.cmd == CMD_MOVE) && isMemMode(req.srcMode))) begin
            result_d.rdValid = 1'b1;
            result_d.rdAddr  = srcEa;
            srcUpd           = modeUpdates(req.srcMode);
            if (req.srcPtr == SP_INDEX) begin
              stackHit = stackFault(srcEa, stackLimit_q);
              stackEa  = srcEa;
            end
          end else begin
            result_d.opndB = default_working_reg_q[req.srcPtr];
          end
          if (isMemMode(req.dstMode)) begin
            result_d.wrValid = 1'b1;
            result_d.wrAddr  = dstEa;
            dstUpd           = modeUpdates(req.dstMode);
            if ((req.dstPtr == SP_INDEX) && !stackHit) begin
              stackHit = stackFault(dstEa, stackLimit_q);
              stackEa  = dstEa;
            end
          end
        end
        CMD_MAC: begin
          if (xOk && yOk) begin
            result_d.rdValid = 1'b1;
            result_d.rdAddr  = xEa;
            result_d.yValid  = 1'b1;
            result_d.yAddr   = yEa;
            xUpd             = 1'b1;
            yUpd             = 1'b1;
          end else begin
            macFault_d = 1'b1;
          end
        end
        CMD_PUSH: begin
          result_d.wrValid = 1'b1;
          result_d.wrAddr  = sp;
          result_d.wrData  = default_working_reg_q[req.srcPtr];
          spUpd            = 1'b1;
          spNew            = sp + WORD_STEP;
          stackHit         = stackFault(sp, stackLimit_q);
        end
        CMD_POP: begin
          result_d.rdValid = 1'b1;
          result_d.rdAddr  = sp - WORD_STEP;
          spUpd            = 1'b1;
          spNew            = sp - WORD_STEP;
          stackHit         = stackFault(sp - WORD_STEP, stackLimit_q);
          stackEa          = sp - WORD_STEP;
        end
        CMD_CALL, CMD_EXCEPTION: begin
          result_d.wrValid = 1'b1;
          result_d.wrAddr  = sp;
          result_d.wrData  = req.pc[DATA_WIDTH-1:0];
          spUpd            = 1'b1;
          spNew            = sp + WORD_STEP;
          stackHit         = stackFault(sp, stackLimit_q);
          if (req.cmd == CMD_CALL) begin
            pushHi_d = {9'h000, req.pc[PC_WIDTH-1:DATA_WIDTH]};
          end else begin
            pushHi_d = {req.statusLowByte, 1'b0, req.pc[PC_WIDTH-1:DATA_WIDTH]};
          end
          state_d = ST_PUSH_HI;
        end
        CMD_BRANCH: begin
          result_d.target = req.pc +
            {{PC_EXT_WIDTH{req.literal[DATA_WIDTH-1]}}, req.literal, 1'b0};
        end
        CMD_INTERRUPT_DISABLE_INSTR: begin
          result_d.disiCount = req.literal[INTERRUPT_DISABLE_INSTR_LIT_WIDTH-1:0];
        end
        default: begin
          result_d.valid = 1'b0;
        end
      endcase
    end
  end

  // Later assignments win: core write-back overrides any pointer update
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < NUM_WREGS; i++) begin
        default_working_reg_q[i] <= (i == int'(SP_INDEX)) ? SP_RESET : 16'h0000;
      end
    end else begin
      if (srcUpd) begin
        default_working_reg_q[req.srcPtr] <= modeNext(req.srcMode, default_working_reg_q[req.srcPtr], step);
      end
      if (dstUpd) begin
        default_working_reg_q[req.dstPtr] <= modeNext(req.dstMode, default_working_reg_q[req.dstPtr], step);
      end
      if (xUpd) begin
        default_working_reg_q[req.xPtr] <= macNext(req.xMac, default_working_reg_q[req.xPtr]);
      end
      if (yUpd) begin
        default_working_reg_q[req.yPtr] <= macNext(req.yMac, default_working_reg_q[req.yPtr]);
      end
      if (spUpd) begin
        default_working_reg_q[SP_INDEX] <= spNew;
      end
      if (coreWrEn) begin
        if (coreWrIdx == SP_INDEX) begin
          default_working_reg_q[SP_INDEX] <= {coreWrData[15:1], 1'b0};
        end else begin
          default_working_reg_q[coreWrIdx] <= coreWrData;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q    <= ST_IDLE;
      pushHi_q   <= 16'h0000;
      reqReady_q <= 1'b1;
      result_q   <= '0;
      macFault_q <= 1'b0;
    end else begin
      state_q    <= state_d;
      pushHi_q   <= pushHi_d;
      reqReady_q <= (state_d == ST_IDLE);
      result_q   <= result_d;
      macFault_q <= macFault_d;
    end
  end

  // A new fault in the acknowledge cycle keeps the request raised
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stackErr_q <= 1'b0;
      trapAddr_q <= 16'h0000;
    end else begin
      if (stackHit) begin
        stackErr_q <= 1'b1;
        trapAddr_q <= stackEa;
      end else if (stackErrAck) begin
        stackErr_q <= 1'b0;
      end
    end
  end

  assign apbWrite = psel && penable && pready_q && pwrite;

  // No reset: contents stay unknown until software writes the limit
  always_ff @(posedge sys_clk) begin
    if (apbWrite && (paddr == OFF_STACK_LIMIT)) begin
      stackLimit_q <= {pwdata[15:1], 1'b0};
    end
  end

  always_comb begin
    rdMux  = 32'h00000000;
    mapped = 1'b1;
    case (paddr)
      OFF_STACK_LIMIT: rdMux[15:0] = {stackLimit_q[15:1], 1'b0};
      OFF_STACK_PTR:   rdMux[15:0] = sp;
      OFF_TRAP_ADDR:   rdMux[15:0] = trapAddr_q;
      OFF_STATUS: begin
        rdMux[ST_ERR_PENDING] = stackErr_q;
        rdMux[ST_PUSH_BUSY]   = (state_q == ST_PUSH_HI);
      end
      default: mapped = 1'b0;
    endcase
  end

  // Answer prepared in setup, so the access phase completes with no wait
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prdata_q  <= 32'h00000000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= psel && !penable;
      pslverr_q <= psel && !penable && !mapped;
      if (psel && !penable && !pwrite) begin
        prdata_q <= rdMux;
      end
    end
  end

  assign prdata      = prdata_q;
  assign pready      = pready_q;
  assign pslverr     = pslverr_q;
  assign reqReady    = reqReady_q;
  assign result      = result_q;
  assign stackErrReq = stackErr_q;
  assign macFault    = macFault_q;

endmodule
`default_nettype wire

// File: src/sla_pkg.sv
package sla_pkg;
  localparam int unsigned DATA_WIDTH     = 16;
  localparam int unsigned PC_WIDTH       = 23;
  localparam int unsigned PC_EXT_WIDTH   = PC_WIDTH - DATA_WIDTH - 1;
  localparam int unsigned INTERRUPT_DISABLE_INSTR_LIT_WIDTH = 14;
  localparam int unsigned APB_ADDR_WIDTH = 12;
  localparam int unsigned NUM_WREGS      = 16;

  localparam logic [3:0]  DEFAULT_DEFAULT_WORKING_REG    = 4'h0;
  localparam logic [3:0]  SP_INDEX        = 4'hf;
  localparam logic [3:0]  MAC_X_PLAIN     = 4'h8;
  localparam logic [3:0]  MAC_X_INDEXED   = 4'h9;
  localparam logic [3:0]  MAC_Y_PLAIN     = 4'ha;
  localparam logic [3:0]  MAC_Y_INDEXED   = 4'hb;

  localparam logic [15:0] DATA_RAM_START  = 16'h0800;
  localparam logic [15:0] SP_RESET        = 16'h0800;
  localparam logic [15:0] NEAR_MASK       = 16'h1fff;
  localparam logic [15:0] SHORT_LIT_MASK  = 16'h001f;
  localparam logic [15:0] BYTE_STEP       = 16'h0001;
  localparam logic [15:0] WORD_STEP       = 16'h0002;
  localparam logic [15:0] MAC_STEP2       = 16'h0002;
  localparam logic [15:0] MAC_STEP4       = 16'h0004;
  localparam logic [15:0] MAC_STEP6       = 16'h0006;

  localparam logic [11:0] OFF_STACK_LIMIT = 12'h000;
  localparam logic [11:0] OFF_STACK_PTR   = 12'h004;
  localparam logic [11:0] OFF_TRAP_ADDR   = 12'h008;
  localparam logic [11:0] OFF_STATUS      = 12'h00c;
  localparam int unsigned ST_ERR_PENDING  = 0;
  localparam int unsigned ST_PUSH_BUSY    = 1;

  typedef enum logic [3:0] {
    CMD_NONE, CMD_FILE, CMD_MCU, CMD_MOVE, CMD_MAC, CMD_PUSH,
    CMD_POP, CMD_CALL, CMD_EXCEPTION, CMD_BRANCH, CMD_INTERRUPT_DISABLE_INSTR
  } sla_cmd_type;

  typedef enum logic [3:0] {
    MODE_DIRECT, MODE_INDIRECT, MODE_POST_INC, MODE_POST_DEC,
    MODE_PRE_INC, MODE_PRE_DEC, MODE_INDEXED, MODE_LIT_OFFSET, MODE_FILE
  } sla_mode_type;

  typedef enum logic [1:0] {OPND_REG, OPND_MEM, OPND_LIT} sla_opnd_type;

  typedef enum logic [2:0] {
    MAC_IND, MAC_INC2, MAC_INC4, MAC_INC6, MAC_DEC2, MAC_DEC4, MAC_DEC6, MAC_INDEXED
  } sla_mac_type;

  typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_PUSH_HI = 1'b1} sla_state_type;

  typedef struct packed {
    sla_cmd_type          cmd;
    sla_mode_type         srcMode;
    logic [3:0]           srcPtr;
    sla_mode_type         dstMode;
    logic [3:0]           dstPtr;
    logic [3:0]           offsetIdx;
    logic                 byteOp;
    sla_opnd_type         opnd2;
    logic [15:0]          literal;
    sla_mac_type          xMac;
    logic [3:0]           xPtr;
    sla_mac_type          yMac;
    logic [3:0]           yPtr;
    logic [PC_WIDTH-1:0]  pc;
    logic [7:0]           statusLowByte;
  } sla_req_type;

  typedef struct packed {
    logic                      valid;
    logic                      rdValid;
    logic [15:0]               rdAddr;
    logic                      yValid;
    logic [15:0]               yAddr;
    logic                      wrValid;
    logic [15:0]               wrAddr;
    logic [15:0]               wrData;
    logic [15:0]               opndA;
    logic [15:0]               opndB;
    logic [PC_WIDTH-1:0]       target;
    logic [INTERRUPT_DISABLE_INSTR_LIT_WIDTH-1:0] disiCount;
  } sla_ea_type;
endpackage

// File: bench/sla_addr_unit_checker.sv
`timescale 1ns/1ps
`default_nettype none
module sla_addr_unit_checker
  import sla_pkg::*;
(
  input wire logic                      sys_clk,
  input wire logic                      rst,
  input wire logic                      psel,
  input wire logic                      penable,
  input wire logic                      pwrite,
  input wire logic [APB_ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0]               prdata,
  input wire logic                      pready,
  input wire logic                      reqValid,
  input wire logic                      reqReady,
  input wire sla_req_type               req,
  input wire sla_ea_type                result,
  input wire logic                      stackErrReq,
  input wire logic                      stackErrAck,
  input wire logic                      macFault
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  wire logic        take  = reqValid && reqReady;
  wire logic [6:0]  pcHi  = req.pc[22:16];
  wire logic [7:0]  stLow = req.statusLowByte;
  wire logic [15:0] lit   = req.literal;
  wire logic [22:0] brDst = req.pc + {{6{req.literal[15]}}, req.literal, 1'b0};

  limit_bit0_a: assert property (
    psel && penable && pready && !pwrite && paddr == OFF_STACK_LIMIT |-> !prdata[0])
    else $error("stack limit bit zero read as one");
  push_result_a: assert property (
    take && req.cmd == CMD_PUSH |=> result.valid && result.wrValid && !result.wrAddr[0])
    else $error("push gave no aligned write");
  call_high_a: assert property (
    take && req.cmd == CMD_CALL |-> ##2 result.valid && result.wrData == {9'h0, $past(pcHi, 2)})
    else $error("call high word wrong");
  exc_high_a: assert property (
    take && req.cmd == CMD_EXCEPTION |-> ##2
      result.valid && result.wrData == {$past(stLow, 2), 1'b0, $past(pcHi, 2)})
    else $error("exception high word wrong");
  err_hold_a: assert property (
    stackErrReq && !stackErrAck |=> stackErrReq)
    else $error("stack error dropped before acceptance");
  err_cause_a: assert property (
    $rose(stackErrReq) |-> result.valid)
    else $error("stack error without an access");
  file_near_a: assert property (
    take && req.cmd == CMD_FILE |=> result.rdAddr == ($past(lit) & NEAR_MASK))
    else $error("file address not limited to near space");
  branch_dst_a: assert property (
    take && req.cmd == CMD_BRANCH |=> result.target == $past(brDst))
    else $error("branch target wrong");
  mac_index_a: assert property (
    take && req.cmd == CMD_MAC && req.xMac == MAC_INDEXED && req.xPtr != MAC_X_INDEXED
      |=> macFault && !result.rdValid && !result.yValid)
    else $error("illegal indexed pointer accepted");
endmodule
`default_nettype wire

// File: bench/sla_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module sla_core_model
  import sla_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       reqReady,
  input  wire sla_ea_type result,
  input  wire logic       stackErrReq,
  output logic            reqValid,
  output sla_req_type     req,
  output logic            stackErrAck,
  output logic            coreWrEn,
  output logic [3:0]      coreWrIdx,
  output logic [15:0]     coreWrData
);
  int ackDelay = 3;
  int waitCnt  = 0;

  initial begin
    reqValid = 1'b0;
    req = '0;
    stackErrAck = 1'b0;
    coreWrEn = 1'b0;
    coreWrIdx = 4'h0;
    coreWrData = 16'h0;
  end

  // Exception logic takes a pending stack error after a few cycles
  always @(posedge sys_clk) begin
    if (rst || !stackErrReq || stackErrAck) begin
      waitCnt <= 0;
      stackErrAck <= 1'b0;
    end else if (waitCnt == ackDelay) begin
      stackErrAck <= 1'b1;
    end else begin
      waitCnt <= waitCnt + 1;
    end
  end

  task automatic send(input sla_req_type r, output sla_ea_type a);
    logic ok;
    @(posedge sys_clk);
    reqValid <= 1'b1;
    req      <= r;
    // Request holds until the edge that samples reqReady high
    do begin
      @(posedge sys_clk);
      ok = reqReady;
    end while (!ok);
    // Released fields carry junk so a stale request cannot pass
    reqValid <= 1'b0;
    req      <= sla_req_type'(~r);
    @(negedge sys_clk);
    a = result;
  endtask

  task automatic default_working_reg(input logic [3:0] idx, input logic [15:0] d);
    @(posedge sys_clk);
    coreWrEn   <= 1'b1;
    coreWrIdx  <= idx;
    coreWrData <= d;
    @(posedge sys_clk);
    coreWrEn   <= 1'b0;
    coreWrData <= ~d;
  endtask
endmodule
`default_nettype wire

// File: bench/sla_addr_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sla_addr_unit_tb
  import sla_pkg::*;
;
  logic         sys_clk = 1'b0;
  logic         rst = 1'b1;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic [11:0]  paddr = 12'h000;
  logic [31:0]  pwdata = 32'h0;
  logic [31:0]  prdata, rd;
  logic         pready, pslverr, reqValid, reqReady, stackErrReq, stackErrAck, macFault;
  logic         coreWrEn, er;
  logic [3:0]   coreWrIdx;
  logic [15:0]  coreWrData, ex, ey;
  sla_req_type  req, r;
  sla_ea_type   result, a;
  int           mismatches = 0;
  int           comparisons = 0;
  int           i;
  sla_mode_type mds [8] = '{MODE_POST_INC, MODE_INDIRECT, MODE_PRE_DEC, MODE_POST_DEC,
                            MODE_PRE_INC, MODE_INDEXED, MODE_LIT_OFFSET, MODE_FILE};
  logic [15:0]  mex [8] = '{16'h1000, 16'h1002, 16'h1000, 16'h1000,
                            16'h1000, 16'h1010, 16'h0ff0, 16'hfff0};
  logic [15:0]  stp [6] = '{16'h0002, 16'h0004, 16'h0006, 16'hfffe, 16'hfffc, 16'hfffa};

  always #5 sys_clk = ~sys_clk;

  sla_addr_unit dut (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .reqValid, .reqReady, .req, .result, .coreWrEn, .coreWrIdx,
    .coreWrData, .stackErrReq, .stackErrAck, .macFault);
  sla_core_model core (.sys_clk, .rst, .reqReady, .result, .stackErrReq, .reqValid, .req,
    .stackErrAck, .coreWrEn, .coreWrIdx, .coreWrData);

  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
    logic ok;
    @(posedge sys_clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= ad;
    pwdata  <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Read data taken at the same edge that samples pready high
    do begin
      @(posedge sys_clk);
      ok = pready;
      rd = prdata;
      er = pslverr;
    end while (!ok);
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~wd;
  endtask

  task automatic rchk(input logic [11:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 32'h0);
    chk("register read", rd, exp);
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #200000;
    mismatches++;
    $display("watchdog expired");
    end_sim();
  end

  initial begin
    r = '0;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    chk("reqReady", reqReady, 1'b1);
    chk("stackErrReq", stackErrReq, 1'b0);
    rchk(OFF_STACK_PTR, 32'h0000_0800);
    apb(1'b1, OFF_STACK_LIMIT, 32'hffff_1003);
    rchk(OFF_STACK_LIMIT, 32'h0000_1002);
    apb(1'b1, OFF_STACK_PTR, 32'h0000_1234);
    rchk(OFF_STACK_PTR, 32'h0000_0800);
    apb(1'b0, 12'h010, 32'h0);
    chk("pslverr", er, 1'b1);
    apb(1'b1, OFF_STACK_LIMIT, 32'h0000_0802);
    core.default_working_reg(4'h1, 16'h1234);
    core.default_working_reg(4'h2, 16'h1000);
    core.default_working_reg(4'h3, 16'h0010);
    for (i = 8; i < 12; i++) core.default_working_reg(i[3:0], i < 10 ? 16'h0900 : 16'h0a00);
    $display("test registers done");
    r.cmd = CMD_PUSH;
    r.srcPtr = 4'h1;
    for (i = 0; i < 3; i++) begin
      core.send(r, a);
      chk("push address", a.wrAddr, 16'h0800 + 16'(2 * i));
      chk("push data", a.wrData, 16'h1234);
      chk("push trap", stackErrReq, i == 2);
    end
    rchk(OFF_TRAP_ADDR, 32'h0000_0804);
    repeat (8) @(posedge sys_clk);
    chk("trap released", stackErrReq, 1'b0);
    apb(1'b1, OFF_STACK_LIMIT, 32'h0000_fffe);
    r.cmd = CMD_POP;
    for (i = 0; i < 4; i++) begin
      core.send(r, a);
      chk("pop address", a.rdAddr, 16'h0804 - 16'(2 * i));
      chk("pop trap", stackErrReq, i == 3);
    end
    core.default_working_reg(SP_INDEX, 16'h0800);
    repeat (8) @(posedge sys_clk);
    $display("test stack done");
    r.cmd = CMD_CALL;
    r.pc = 23'h5a1234;
    r.statusLowByte = 8'ha5;
    core.send(r, a);
    chk("call low", a.wrData, 16'h1234);
    @(negedge sys_clk);
    chk("call high", result.wrData, 16'h005a);
    chk("call high address", result.wrAddr, 16'h0802);
    r.cmd = CMD_EXCEPTION;
    core.send(r, a);
    @(negedge sys_clk);
    chk("exception high", result.wrData, 16'ha55a);
    $display("test calls done");
    r = '0;
    r.cmd = CMD_MOVE;
    r.srcPtr = 4'h2;
    r.offsetIdx = 4'h3;
    r.literal = 16'hfff0;
    for (i = 0; i < 8; i++) begin
      r.srcMode = mds[i];
      core.send(r, a);
      chk("source address", a.rdAddr, mex[i]);
    end
    r.srcMode = MODE_INDEXED;
    r.dstMode = MODE_POST_INC;
    r.dstPtr = 4'h3;
    core.send(r, a);
    chk("move source", a.rdAddr, 16'h1010);
    chk("move destination", a.wrAddr, 16'h0010);
    r = '0;
    r.cmd = CMD_FILE;
    r.literal = 16'hffff;
    core.send(r, a);
    chk("file address", a.rdAddr, 16'h1fff);
    r.cmd = CMD_MCU;
    r.offsetIdx = 4'h3;
    r.opnd2 = OPND_LIT;
    core.send(r, a);
    chk("base operand", a.opndA, 16'h0012);
    chk("literal operand", a.opndB, 16'h001f);
    r.cmd = CMD_BRANCH;
    r.pc = 23'h000100;
    r.literal = 16'hfffe;
    core.send(r, a);
    chk("branch target", a.target, 23'h0000fc);
    r.cmd = CMD_INTERRUPT_DISABLE_INSTR;
    r.literal = 16'hffff;
    core.send(r, a);
    chk("disable count", a.disiCount, 14'h3fff);
    $display("test modes done");
    r = '0;
    r.cmd = CMD_MAC;
    r.xPtr = MAC_X_PLAIN;
    r.yPtr = MAC_Y_PLAIN;
    ex = 16'h0900;
    ey = 16'h0a00;
    for (i = 0; i < 7; i++) begin
      r.xMac = sla_mac_type'(i[2:0]);
      r.yMac = r.xMac;
      core.send(r, a);
      chk("mac x address", a.rdAddr, ex);
      chk("mac y address", a.yAddr, ey);
      if (i > 0) begin
        ex = ex + stp[i-1];
        ey = ey + stp[i-1];
      end
    end
    r.xPtr = MAC_X_INDEXED;
    r.yPtr = MAC_Y_INDEXED;
    r.xMac = MAC_INDEXED;
    r.yMac = MAC_INDEXED;
    r.offsetIdx = 4'h3;
    core.send(r, a);
    chk("mac x indexed", a.rdAddr, 16'h0912);
    chk("mac y indexed", a.yAddr, 16'h0a12);
    r.xPtr = MAC_X_PLAIN;
    core.send(r, a);
    chk("mac index fault", macFault, 1'b1);
    chk("mac fault result", {a.rdValid, a.yValid}, 2'b00);
    r.xPtr = 4'h0;
    r.xMac = MAC_IND;
    core.send(r, a);
    chk("mac pointer fault", macFault, 1'b1);
    $display("test mac done");
    end_sim();
  end
endmodule

bind sla_addr_unit sla_addr_unit_checker u_chk (.sys_clk, .rst, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .reqValid, .reqReady, .req, .result, .stackErrReq, .stackErrAck,
  .macFault);
`default_nettype wire
